// ===== dfcs_defines.svh
// Bit positions, reset values and timing counts for the fieldbus control and status block.
`ifndef DFCS_DEFINES_SVH
`define DFCS_DEFINES_SVH

// ----------------------------------------
// Command word bit positions
// ----------------------------------------
`define DFCS_CW_ON 0
`define DFCS_CW_COAST_N 1
`define DFCS_CW_QUICK_N 2
`define DFCS_CW_START 3
`define DFCS_CW_RAMP_OUT 4
`define DFCS_CW_RAMP_HOLD 5
`define DFCS_CW_RAMP_IN 6
`define DFCS_CW_FAULT_RST 7
`define DFCS_CW_INCH_1 8
`define DFCS_CW_INCH_2 9
`define DFCS_CW_BUS_EN 10
`define DFCS_CW_WD_PULSE 11
`define DFCS_CW_DIN_LO 11
`define DFCS_CW_DIN_HI 15

// ----------------------------------------
// State word bit positions and masks
// ----------------------------------------
`define DFCS_SW_FAULT 3
`define DFCS_SW_WARN 7
`define DFCS_SW_AT_REF 8
`define DFCS_SW_RUNNING 12
`define DFCS_SW_READY 13
`define DFCS_SW_BOARD_MASK 16'h0277

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define DFCS_CMD_RST 16'h0000
`define DFCS_STATUS_RST 16'h0000
`define DFCS_CLK_HZ 125000000
`define DFCS_WD_PERIOD_MS 1000
`define DFCS_WD_CYC ((`DFCS_WD_PERIOD_MS) * ((`DFCS_CLK_HZ) / 1000))

`endif

// ===== dfcs_pkg.sv
// Types shared by the fieldbus control and status block.
package dfcs_pkg;

	typedef enum logic {
		dfcs_layout_one = 1'b0,
		dfcs_layout_two = 1'b1
	} dfcs_layout_t;

	typedef enum logic [1:0] {
		dfcs_st_inhibit = 2'b00,
		dfcs_st_sw_on = 2'b01,
		dfcs_st_operate = 2'b11,
		dfcs_st_run = 2'b10
	} dfcs_state_t;

endpackage

// ===== dfcs_edge.sv
// Rising edge detector for command word bits.
`timescale 1ns/1ps
module dfcs_edge #(
	parameter int W = 2
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);

	logic [W-1:0] level_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= '0;
		end else begin
			level_q <= level;
		end
	end

	assign rise = level & ~level_q;

	chk_edge_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
		(rise != '0) |=> ((rise & $past(rise)) == '0))
		else $error("edge pulse lasted more than one cycle");

endmodule

// ===== dfcs_watchdog.sv
// Monitor of the master's watchdog square wave.
`timescale 1ns/1ps
module dfcs_watchdog #(
	parameter int unsigned TIMEOUT_CYC = 1000
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic pulse,
	input wire logic clear,
	output logic fault_q
);

	localparam logic [31:0] LAST = 32'(TIMEOUT_CYC - 1);

	logic pulse_q;
	logic [31:0] cnt_q;
	logic toggle;
	logic timeout;

	assign toggle = pulse ^ pulse_q;
	assign timeout = enable && !toggle && (cnt_q == LAST);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= pulse;
		end
	end

	// The count saturates so that a dead master keeps the fault raised.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
		end else if (!enable || toggle) begin
			cnt_q <= 32'h0;
		end else if (cnt_q != LAST) begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
		end else if (timeout) begin
			fault_q <= 1'b1;
		end else if (clear) begin
			fault_q <= 1'b0;
		end
	end

	chk_wd_timeout_fault: assert property (@(posedge mclk) disable iff (!rst_n)
		timeout |=> fault_q)
		else $error("missing watchdog pulse did not raise the fault");

	chk_wd_idle_count: assert property (@(posedge mclk) disable iff (!rst_n)
		(!enable || toggle) |=> (cnt_q == 32'h0) && !timeout)
		else $error("watchdog count not restarted");

	chk_wd_fault_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		(clear && !timeout) |=> !fault_q)
		else $error("watchdog fault not cleared");

endmodule

// ===== dfcs_control_status.sv
// Fieldbus command word decoder and state word builder of the motor drive.
// Operation
// - Layout one: bit7 rising edge clears faults
// - Layout one: bit10 selects fieldbus control
// - Status bits 3,7,8,12,13 from drive conditions
// - Status bits 0-2,4-6,9 from board machine
// - Layout two: bit0 rising leaves switch-on inhibit
// - Layout two: bit1 low requests coast stop
// - Layout two: bit2 low requests quick stop
// - Layout two: bit3 high starts, low stops
// - Layout two: bit4 low zeroes ramp output
// - Layout two: bit5 low holds ramp output
// - Layout two: bit6 low zeroes ramp input
// - Layout two: bit7 high resets faults
// - Layout two: bits8,9 select inching speeds
// - Layout two: bit10 enables fieldbus when selected
// - Watchdog square wave; missing pulse raises fault
// - Bit0 low: ramped stop to ready state
// - Coast stop ends in switch-on inhibit
// - Bit4 outranks bits 5 and 6
`timescale 1ns/1ps
`include "dfcs_defines.svh"
module dfcs_control_status #(
	parameter int unsigned WD_TIMEOUT_CYC = `DFCS_WD_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire dfcs_pkg::dfcs_layout_t layout_sel,
	input wire logic [15:0] cmd_word,
	input wire logic cmd_valid,
	input wire logic bus_place_sel,
	input wire logic wd_enable,
	input wire logic [15:0] bus_board_state_machine_status,
	input wire logic drive_fault,
	input wire logic drive_warning,
	input wire logic drive_at_ref,
	input wire logic drive_running,
	input wire logic drive_ready,
	output logic [15:0] layout_one_state_word_q,
	output logic run_cmd_q,
	output logic bus_ctrl_q,
	output logic fault_reset_q,
	output logic [4:0] remote_digital_input_q,
	output logic coast_stop_q,
	output logic quick_stop_q,
	output logic ramp_out_zero_q,
	output logic ramp_hold_q,
	output logic ramp_in_zero_q,
	output logic inch_1_q,
	output logic inch_2_q,
	output logic comm_fault_q,
	output dfcs_pkg::dfcs_state_t drive_state_q
);

	// ----------------------------------------
	// Command word capture
	// ----------------------------------------
	logic [15:0] command_word_q;
	logic layout_two;
	logic on_rise;
	logic fault_ack_rise;
	logic bus_act_d;
	logic stop_forced;
	dfcs_pkg::dfcs_state_t st_d;
	logic [15:0] status_d;

	assign layout_two = (layout_sel == dfcs_pkg::dfcs_layout_two);

	// Both layouts share one capture register; the layout only changes its decoding.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			command_word_q <= `DFCS_CMD_RST;
		end else if (cmd_valid) begin
			command_word_q <= cmd_word;
		end
	end

	dfcs_edge #(
		.W(2)
	) u_edge (
		.mclk(mclk),
		.rst_n(rst_n),
		.level({command_word_q[`DFCS_CW_FAULT_RST], command_word_q[`DFCS_CW_ON]}),
		.rise({fault_ack_rise, on_rise})
	);

	dfcs_watchdog #(
		.TIMEOUT_CYC(WD_TIMEOUT_CYC)
	) u_watchdog (
		.mclk(mclk),
		.rst_n(rst_n),
		.enable(wd_enable && layout_two),
		.pulse(command_word_q[`DFCS_CW_WD_PULSE]),
		.clear(fault_reset_q),
		.fault_q(comm_fault_q)
	);

	// ----------------------------------------
	// Fieldbus control selection
	// ----------------------------------------
	assign bus_act_d = layout_two ?
		(command_word_q[`DFCS_CW_BUS_EN] && bus_place_sel) :
		command_word_q[`DFCS_CW_BUS_EN];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ctrl_q <= 1'b0;
		end else begin
			bus_ctrl_q <= bus_act_d;
		end
	end

	// ----------------------------------------
	// Layout two drive state machine
	// ----------------------------------------
	// Losing fieldbus control while running is handled as a coast stop.
	assign stop_forced = !layout_two || !bus_act_d || drive_fault || comm_fault_q ||
		!command_word_q[`DFCS_CW_COAST_N] ||
		!command_word_q[`DFCS_CW_QUICK_N];

	always_comb begin
		st_d = drive_state_q;
		if (stop_forced) begin
			st_d = dfcs_pkg::dfcs_st_inhibit;
		end else begin
			unique case (drive_state_q)
				dfcs_pkg::dfcs_st_inhibit: begin
					if (on_rise) begin
						st_d = dfcs_pkg::dfcs_st_sw_on;
					end
				end
				dfcs_pkg::dfcs_st_sw_on: begin
					if (command_word_q[`DFCS_CW_ON]) begin
						st_d = dfcs_pkg::dfcs_st_operate;
					end
				end
				dfcs_pkg::dfcs_st_operate: begin
					if (!command_word_q[`DFCS_CW_ON]) begin
						st_d = dfcs_pkg::dfcs_st_sw_on;
					end else if (command_word_q[`DFCS_CW_START]) begin
						st_d = dfcs_pkg::dfcs_st_run;
					end
				end
				dfcs_pkg::dfcs_st_run: begin
					if (!command_word_q[`DFCS_CW_ON]) begin
						st_d = dfcs_pkg::dfcs_st_sw_on;
					end else if (!command_word_q[`DFCS_CW_START]) begin
						st_d = dfcs_pkg::dfcs_st_operate;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			drive_state_q <= dfcs_pkg::dfcs_st_inhibit;
		end else begin
			drive_state_q <= st_d;
		end
	end

	// ----------------------------------------
	// Run, stop and fault reset commands
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			run_cmd_q <= 1'b0;
			coast_stop_q <= 1'b0;
			quick_stop_q <= 1'b0;
		end else begin
			if (layout_two) begin
				run_cmd_q <= (st_d == dfcs_pkg::dfcs_st_run);
			end else begin
				run_cmd_q <= command_word_q[`DFCS_CW_START] && bus_act_d;
			end
			coast_stop_q <= layout_two && !command_word_q[`DFCS_CW_COAST_N];
			quick_stop_q <= layout_two && !command_word_q[`DFCS_CW_QUICK_N];
		end
	end

	// Layout one acts on the edge only, so a bit left high cannot hold faults cleared.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_reset_q <= 1'b0;
		end else if (layout_two) begin
			fault_reset_q <= command_word_q[`DFCS_CW_FAULT_RST];
		end else begin
			fault_reset_q <= fault_ack_rise;
		end
	end

	// ----------------------------------------
	// Ramp and inching commands
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_out_zero_q <= 1'b0;
			ramp_hold_q <= 1'b0;
			ramp_in_zero_q <= 1'b0;
			inch_1_q <= 1'b0;
			inch_2_q <= 1'b0;
		end else begin
			ramp_out_zero_q <= layout_two && !command_word_q[`DFCS_CW_RAMP_OUT];
			ramp_hold_q <= layout_two && command_word_q[`DFCS_CW_RAMP_OUT] &&
				!command_word_q[`DFCS_CW_RAMP_HOLD];
			ramp_in_zero_q <= layout_two && command_word_q[`DFCS_CW_RAMP_OUT] &&
				command_word_q[`DFCS_CW_RAMP_HOLD] && !command_word_q[`DFCS_CW_RAMP_IN];
			// Both inching requests together mean stop.
			inch_1_q <= layout_two && command_word_q[`DFCS_CW_INCH_1] && !command_word_q[`DFCS_CW_INCH_2];
			inch_2_q <= layout_two && command_word_q[`DFCS_CW_INCH_2] && !command_word_q[`DFCS_CW_INCH_1];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			remote_digital_input_q <= 5'h00;
		end else if (layout_two) begin
			remote_digital_input_q <= 5'h00;
		end else begin
			remote_digital_input_q <= command_word_q[`DFCS_CW_DIN_HI:`DFCS_CW_DIN_LO];
		end
	end

	// ----------------------------------------
	// State word
	// ----------------------------------------
	always_comb begin
		status_d = bus_board_state_machine_status & `DFCS_SW_BOARD_MASK;
		status_d[`DFCS_SW_FAULT] = drive_fault;
		status_d[`DFCS_SW_WARN] = drive_warning;
		status_d[`DFCS_SW_AT_REF] = drive_at_ref;
		status_d[`DFCS_SW_RUNNING] = drive_running;
		status_d[`DFCS_SW_READY] = drive_ready;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			layout_one_state_word_q <= `DFCS_STATUS_RST;
		end else begin
			layout_one_state_word_q <= status_d;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_leave_inhibit;
		(drive_state_q == dfcs_pkg::dfcs_st_inhibit) && on_rise && !stop_forced;
	endsequence

	sequence s_start;
		(drive_state_q == dfcs_pkg::dfcs_st_operate) && command_word_q[`DFCS_CW_ON] &&
			command_word_q[`DFCS_CW_START] && !stop_forced;
	endsequence

	sequence s_ramp_stop;
		(drive_state_q != dfcs_pkg::dfcs_st_inhibit) && (drive_state_q != dfcs_pkg::dfcs_st_sw_on) &&
			!command_word_q[`DFCS_CW_ON] && !stop_forced;
	endsequence

	chk_l1_run_enable: assert property (!layout_two |=>
		run_cmd_q == $past(command_word_q[`DFCS_CW_START] && command_word_q[`DFCS_CW_BUS_EN]))
		else $error("layout one run command wrong");

	chk_l1_fault_edge: assert property (!layout_two |=> fault_reset_q == $past(fault_ack_rise))
		else $error("layout one fault reset not edge driven");

	chk_l1_steady_level: assert property (!layout_two && $stable(command_word_q)
		##1 !layout_two && $stable(command_word_q) |=> !fault_reset_q)
		else $error("steady fault reset level acted");

	chk_l1_bus_select: assert property (!layout_two |=> bus_ctrl_q == $past(command_word_q[`DFCS_CW_BUS_EN]))
		else $error("layout one fieldbus select wrong");

	chk_status_drive_bits: assert property (1'b1 |=>
		layout_one_state_word_q[`DFCS_SW_FAULT] == $past(drive_fault) &&
		layout_one_state_word_q[`DFCS_SW_WARN] == $past(drive_warning) &&
		layout_one_state_word_q[`DFCS_SW_RUNNING] == $past(drive_running) &&
		layout_one_state_word_q[`DFCS_SW_READY] == $past(drive_ready))
		else $error("drive status bits wrong");

	chk_status_board_bits: assert property (1'b1 |=>
		(layout_one_state_word_q & `DFCS_SW_BOARD_MASK) ==
		($past(bus_board_state_machine_status) & `DFCS_SW_BOARD_MASK))
		else $error("board status bits wrong");

	chk_sw_on_leave: assert property (s_leave_inhibit |=> drive_state_q == dfcs_pkg::dfcs_st_sw_on)
		else $error("rising on bit did not leave inhibit");

	chk_coast_stop: assert property (layout_two && !command_word_q[`DFCS_CW_COAST_N] |=>
		coast_stop_q && drive_state_q == dfcs_pkg::dfcs_st_inhibit)
		else $error("coast stop not applied");

	chk_quick_stop: assert property (layout_two && !command_word_q[`DFCS_CW_QUICK_N] |=>
		quick_stop_q && !run_cmd_q)
		else $error("quick stop not applied");

	chk_start_run: assert property (s_start |=> drive_state_q == dfcs_pkg::dfcs_st_run && run_cmd_q)
		else $error("start did not run the drive");

	chk_ramp_priority: assert property (layout_two |=>
		ramp_out_zero_q == !$past(command_word_q[`DFCS_CW_RAMP_OUT]) &&
		(ramp_out_zero_q ? !ramp_hold_q && !ramp_in_zero_q :
		ramp_hold_q == !$past(command_word_q[`DFCS_CW_RAMP_HOLD]) &&
		(ramp_hold_q || ramp_in_zero_q == !$past(command_word_q[`DFCS_CW_RAMP_IN]))))
		else $error("ramp commands resolved wrongly");

	chk_l2_fault_reset: assert property (layout_two |=> fault_reset_q == $past(command_word_q[`DFCS_CW_FAULT_RST]))
		else $error("layout two fault reset wrong");

	chk_inching_select: assert property (layout_two |=>
		inch_1_q == $past(command_word_q[`DFCS_CW_INCH_1] && !command_word_q[`DFCS_CW_INCH_2]) &&
		inch_2_q == $past(command_word_q[`DFCS_CW_INCH_2] && !command_word_q[`DFCS_CW_INCH_1]))
		else $error("inching selection wrong");

	chk_bus_place: assert property (layout_two && !bus_place_sel |=>
		!bus_ctrl_q && drive_state_q == dfcs_pkg::dfcs_st_inhibit)
		else $error("fieldbus control active without place selection");

	chk_comm_fault_stop: assert property (layout_two && comm_fault_q |=>
		drive_state_q == dfcs_pkg::dfcs_st_inhibit && !run_cmd_q)
		else $error("communication fault did not stop the drive");

	chk_ramped_stop: assert property (s_ramp_stop |=>
		drive_state_q == dfcs_pkg::dfcs_st_sw_on && !run_cmd_q)
		else $error("off command did not return to ready");

endmodule

// ===== dfcs_master_model.sv
// Fieldbus master model that writes command words and keeps the watchdog square wave going.
`timescale 1ns/1ps
module dfcs_master_model #(
	parameter int HALF = 10
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire dfcs_pkg::dfcs_layout_t layout_sel,
	input wire logic [15:0] req_word,
	input wire logic req_valid,
	input wire logic wd_run,
	output logic [15:0] cmd_word,
	output logic cmd_valid
);
	int cnt;
	logic wd_bit;

	// ----------------------------------------
	// Watchdog square wave
	// ----------------------------------------
	// The wave steps by non-blocking assignment on the capture edge, so the block always takes the settled bit.
	// Sampling wd_run on the rising edge also keeps the model clear of the bench, which drives on the falling edge.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			wd_bit <= 1'b0;
		end else if (wd_run) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) begin
				wd_bit <= ~wd_bit;
			end
		end
	end

	// ----------------------------------------
	// Word driven toward the block
	// ----------------------------------------
	// While the wave runs the word is rewritten every cycle, so a stopped master means a frozen bit.
	always_comb begin
		cmd_word = req_word;
		cmd_valid = req_valid | wd_run;
		if (layout_sel == dfcs_pkg::dfcs_layout_one) begin
			cmd_word = req_word | 16'h0077;
		end else if (wd_run) begin
			cmd_word[11] = wd_bit;
		end
	end
endmodule

// ===== tb_top.sv
// Self-checking testbench of the fieldbus control and status block.
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	dfcs_pkg::dfcs_layout_t layout_sel = dfcs_pkg::dfcs_layout_one;
	logic [15:0] req_word = 16'h0000;
	logic req_valid = 1'b0;
	logic wd_run = 1'b0;
	logic bus_place_sel = 1'b0;
	logic wd_enable = 1'b0;
	logic [15:0] board = 16'h0000;
	logic [4:0] cond = 5'h00;
	logic [15:0] cmd_word;
	logic cmd_valid;
	logic [15:0] state_word;
	logic run_cmd_q, bus_ctrl_q, fault_reset_q, coast_stop_q, quick_stop_q;
	logic ramp_out_zero_q, ramp_hold_q, ramp_in_zero_q, inch_1_q, inch_2_q, comm_fault_q;
	logic [4:0] din_q;
	dfcs_pkg::dfcs_state_t drive_state_q;
	int mismatches = 0;
	int total_checks = 0;
	logic [15:0] sm_word [10] = '{16'h0406, 16'h0407, 16'h0407, 16'h040F, 16'h040E,
		16'h040D, 16'h040F, 16'h040E, 16'h040F, 16'h040B};
	int sm_wait [10] = '{0, 0, 0, 0, 1, 0, 2, 0, 2, 0};
	// Expected {state, run command}: inhibit 0, ready 2, operate 6, run 5.
	logic [2:0] sm_exp [10] = '{3'h0, 3'h2, 3'h6, 3'h5, 3'h2, 3'h0, 3'h0, 3'h0, 3'h5, 3'h0};

	always #4 mclk = ~mclk;

	dfcs_master_model #(.HALF(10)) u_dfcs_master_model (.mclk(mclk), .rst_n(rst_n), .layout_sel(layout_sel),
		.req_word(req_word), .req_valid(req_valid), .wd_run(wd_run), .cmd_word(cmd_word), .cmd_valid(cmd_valid));

	dfcs_control_status #(.WD_TIMEOUT_CYC(20)) u_dfcs_control_status (.mclk(mclk), .rst_n(rst_n),
		.layout_sel(layout_sel), .cmd_word(cmd_word), .cmd_valid(cmd_valid), .bus_place_sel(bus_place_sel),
		.wd_enable(wd_enable), .bus_board_state_machine_status(board), .drive_fault(cond[0]),
		.drive_warning(cond[1]), .drive_at_ref(cond[2]), .drive_running(cond[3]), .drive_ready(cond[4]),
		.layout_one_state_word_q(state_word), .run_cmd_q(run_cmd_q), .bus_ctrl_q(bus_ctrl_q),
		.fault_reset_q(fault_reset_q), .remote_digital_input_q(din_q), .coast_stop_q(coast_stop_q),
		.quick_stop_q(quick_stop_q), .ramp_out_zero_q(ramp_out_zero_q), .ramp_hold_q(ramp_hold_q),
		.ramp_in_zero_q(ramp_in_zero_q), .inch_1_q(inch_1_q), .inch_2_q(inch_2_q),
		.comm_fault_q(comm_fault_q), .drive_state_q(drive_state_q));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Called at a falling edge; returns waits falling edges after the one that follows the move of the decoded outputs.
	task automatic send(input logic [15:0] w, input int waits);
		req_word = w;
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		repeat (waits + 1) @(negedge mclk);
	endtask

	task automatic complete_run;
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check_one;
		check("layout one", {8'h00, run_cmd_q, bus_ctrl_q, fault_reset_q, din_q}, 16'h0000);
	endtask

	initial begin
		#20000;
		mismatches++;
		complete_run();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(negedge mclk);
		check("reset word", 16'h0000, state_word);
		check("reset state", 16'h0000, {14'h0000, drive_state_q});
		rst_n = 1'b1;
		@(negedge mclk);
		board = 16'hFFFF;
		cond = 5'h1F;
		@(negedge mclk);
		check("state word", 16'h33FF, state_word);
		board = 16'hFD88;
		cond = 5'h00;
		@(negedge mclk);
		check("state word", 16'h0000, state_word);
		board = 16'h0255;
		cond = 5'h15;
		@(negedge mclk);
		check("state word", 16'h235D, state_word);
		cond = 5'h10;
		send(16'hA408, 0);
		check("layout one", 16'h00D4, {8'h00, run_cmd_q, bus_ctrl_q, fault_reset_q, din_q});
		send(16'hA488, 0);
		check("layout one", 16'h00F4, {8'h00, run_cmd_q, bus_ctrl_q, fault_reset_q, din_q});
		@(negedge mclk);
		check("layout one", 16'h00D4, {8'h00, run_cmd_q, bus_ctrl_q, fault_reset_q, din_q});
		send(16'h5000, 0);
		check("layout one", 16'h000A, {8'h00, run_cmd_q, bus_ctrl_q, fault_reset_q, din_q});
		send(16'h1008, 0);
		check("layout one", 16'h0002, {8'h00, run_cmd_q, bus_ctrl_q, fault_reset_q, din_q});
		layout_sel = dfcs_pkg::dfcs_layout_two;
		bus_place_sel = 1'b1;
		for (int i = 0; i < 8; i++) begin
			send(16'h0406 | 16'(i << 4), 0);
			check("ramp", {13'h0000, ~i[0], i[0] & ~i[1], i[0] & i[1] & ~i[2]},
				{13'h0000, ramp_out_zero_q, ramp_hold_q, ramp_in_zero_q});
		end
		for (int j = 0; j < 4; j++) begin
			bus_place_sel = j[0];
			send({5'h00, j[1], j[1], j[0], j[0], 3'h7, 1'b0, j[1], j[0], 1'b0}, 0);
			check("decode", {10'h000, j[1] & j[0], j[0], j[1] & ~j[0], j[0] & ~j[1], ~j[1], ~j[0]},
				{10'h000, bus_ctrl_q, fault_reset_q, inch_2_q, inch_1_q, quick_stop_q, coast_stop_q});
		end
		bus_place_sel = 1'b1;
		for (int k = 0; k < 10; k++) begin
			send(sm_word[k], sm_wait[k]);
			check("state", {13'h0000, sm_exp[k]}, {13'h0000, drive_state_q, run_cmd_q});
		end
		wd_enable = 1'b1;
		wd_run = 1'b1;
		repeat (60) @(negedge mclk);
		check("watchdog", 16'h0000, {15'h0000, comm_fault_q});
		wd_run = 1'b0;
		repeat (30) @(negedge mclk);
		check("watchdog", 16'h0001, {15'h0000, comm_fault_q});
		wd_run = 1'b1;
		repeat (12) @(negedge mclk);
		send(16'h0486, 0);
		send(16'h0406, 1);
		check("watchdog", 16'h0000, {15'h0000, comm_fault_q});
		complete_run();
	end
endmodule
